// ---- design/rbpa_pkg.sv ----
// Purpose: Constants and types for the bypass alignment block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Delay tap of 512 steps, centre at step 256.
//
// Behaviour
// [RL1] Bypass gives fixed low latency; no clock correction or bonding.
// [RL2] Phase alignment shifts recovered clock to match both parallel clocks.
// [RL3] PCS clock is recovered clock when buffered, user clock when bypassed.
// [RL4] Buffer enable true uses the buffer (default); false bypasses it.
// [RL5] Controller never sets slide mode automatic or PMA while bypassed.
// [RL6] Hard reset jumps delay tap to centre and starts automatic alignment.
// [RL7] Soft reset walks delay tap to centre and starts automatic alignment.
// [RL8] Bit 13 picks full tap range at 1, half at 0.
// [RL9] Power-down high stops the circuit; controller drives it.
// [RL10] Phase override loads phase counter from phase word bits 10 to 6.
// [RL11] Delay override loads delay counter from delay word bits 14 to 6.
// [RL12] Delay bypass at 1 skips delay alignment; 0 uses it.
// [RL13] Controller holds phase command and enable low in automatic mode.
// [RL14] Alignment done at second done rise after soft-reset-done.
// [RL15] Lane role 0 slave, 1 master; high in single lane.
// [RL16] All-lanes-done input is own done, or AND of all lanes.
// [RL17] Master sync output feeds every lane sync input.
// [RL18] Sync-done marks completion; valid on automatic master only.
// [RL19] Multi-lane setting: 0 single lane, 1 group member.
// [RL20] Skip-delay setting: 0 performs delay alignment, 1 omits it.
// [RL21] Manual override 0 runs automatic control; 1 leaves it to controller.
// [RL22] Single lanes run automatic only; groups manual or automatic.
// [RL23] Controller awaits idle exit and lock before soft reset.
// [RL24] Soft-reset-done stays high at least 100 ns once raised.
// [RL25] Controller synchronises done and error flags before use; the bench controller synchronises soft-reset-done only.

package rbpa_pkg;

    // ====
    // Widths and field positions
    localparam int PHASE_W = 5;
    localparam int DELAY_W = 9;
    localparam int PH_OVRD_HI = 10;
    localparam int PH_OVRD_LO = 6;
    localparam int DLY_OVRD_HI = 14;
    localparam int DLY_OVRD_LO = 6;
    localparam int TAP_RANGE_BIT = 13;

    // ====
    // Tap positions
    localparam logic [PHASE_W-1:0] PHASE_CENTER = 5'h10;
    localparam logic [PHASE_W-1:0] PHASE_MIN = 5'h00;
    localparam logic [PHASE_W-1:0] PHASE_MAX = 5'h1f;
    localparam logic [DELAY_W-1:0] DELAY_CENTER = 9'h100;
    localparam logic [DELAY_W-1:0] DELAY_FULL_MIN = 9'h000;
    localparam logic [DELAY_W-1:0] DELAY_FULL_MAX = 9'h1ff;
    localparam logic [DELAY_W-1:0] DELAY_HALF_MIN = 9'h080;
    localparam logic [DELAY_W-1:0] DELAY_HALF_MAX = 9'h17f;

    // ====
    // Slide mode encodings
    localparam logic [1:0] SLIDE_OFF = 2'h0;
    localparam logic [1:0] SLIDE_AUTO = 2'h1;
    localparam logic [1:0] SLIDE_PCS = 2'h2;
    localparam logic [1:0] SLIDE_PMA = 2'h3;

    // ====
    // Timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SRD_MIN_NS = 100;
    localparam int SRD_MIN_CYC = (SRD_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SRD_CNT_W = 5;
    localparam logic [SRD_CNT_W-1:0] SRD_MIN_CNT = SRD_CNT_W'(SRD_MIN_CYC);

    // ====
    // Automatic sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CENTER,
        ST_SYNC_WAIT,
        ST_PHASE,
        ST_DELAY,
        ST_WAIT_ALL,
        ST_TRACK
    } rbpa_state_t;

endpackage : rbpa_pkg

// ---- design/rbpa_tap_if.sv ----
// Purpose: Sequencer to tap counter bundle.
// Assumes: Commands are levels.
// Notes: Width is set per instance.
`timescale 1ns/1ps

interface rbpa_tap_if #(parameter int W = 5);
    logic load_center;
    logic seek_center;
    logic step_up;
    logic step_down;
    logic ovrd_en;
    logic [W-1:0] ovrd_val;
    logic [W-1:0] center;
    logic [W-1:0] lo_lim;
    logic [W-1:0] hi_lim;
    logic [W-1:0] value;
    logic at_center;
    logic at_lo;
    logic at_hi;

    modport ctrl (
        output load_center, seek_center, step_up, step_down, ovrd_en, ovrd_val, center, lo_lim, hi_lim,
        input value, at_center, at_lo, at_hi
    );
    modport unit (
        input load_center, seek_center, step_up, step_down, ovrd_en, ovrd_val, center, lo_lim, hi_lim,
        output value, at_center, at_lo, at_hi
    );
endinterface : rbpa_tap_if

// ---- design/rbpa_tap_unit.sv ----
// Purpose: Bounded tap counter with override, jump and walk to centre.
// Assumes: Priority is override, jump, walk, then steps.
// Notes: Steps stay within the limits.
`timescale 1ns/1ps

module rbpa_tap_unit #(parameter int W = 5) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Command side
    rbpa_tap_if.unit tap
);

    // ====
    // Tap register
    logic [W-1:0] value_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            value_q <= '0;
        end else if (tap.ovrd_en) begin
            value_q <= tap.ovrd_val;
        end else if (tap.load_center) begin
            value_q <= tap.center;
        end else if (tap.seek_center) begin
            if (value_q < tap.center) begin
                value_q <= value_q + W'(1);
            end else if (value_q > tap.center) begin
                value_q <= value_q - W'(1);
            end
        end else if (tap.step_up && value_q < tap.hi_lim) begin
            value_q <= value_q + W'(1);
        end else if (tap.step_down && value_q > tap.lo_lim) begin
            value_q <= value_q - W'(1);
        end
    end

    assign tap.value = value_q;
    assign tap.at_center = (value_q == tap.center);
    assign tap.at_lo = (value_q <= tap.lo_lim);
    assign tap.at_hi = (value_q >= tap.hi_lim);

endmodule : rbpa_tap_unit

// ---- design/rbpa_align.sv ----
// Purpose: Bypass phase and delay alignment controller for one lane.
// Assumes: Control inputs are synchronous to clock.
// Notes: Detectors report lead, lag and aligned.
`timescale 1ns/1ps

module rbpa_align (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Alignment controls
    input wire logic align_hard_reset,
    input wire logic delay_soft_reset,
    input wire logic phase_align_cmd,
    input wire logic phase_align_enable,
    input wire logic align_power_down,
    input wire logic phase_counter_override_en,
    input wire logic delay_circuit_bypass,
    input wire logic delay_align_enable,
    input wire logic delay_counter_override_en,
    // Lane group
    input wire logic lane_role_select,
    input wire logic all_lanes_done_in,
    input wire logic group_sync_in,
    output logic group_sync_out,
    // Settings
    input wire logic elastic_buffer_use,
    input wire logic pcs_clock_source_select,
    input wire logic [23:0] phase_config_word,
    input wire logic [15:0] phase_delay_config_word,
    input wire logic [15:0] delay_config_word,
    input wire logic multi_lane_setting,
    input wire logic skip_delay_setting,
    input wire logic manual_override_setting,
    input wire logic [1:0] slide_mode_setting,
    // Detectors
    input wire logic phase_detect_valid,
    input wire logic phase_detect_lead,
    input wire logic phase_detect_aligned,
    input wire logic delay_detect_valid,
    input wire logic delay_detect_lead,
    input wire logic delay_detect_aligned,
    // Status flags
    output logic phase_align_done_flag,
    output logic soft_reset_done_flag,
    output logic sync_done_flag,
    output logic phase_align_error_flag,
    output logic config_fault,
    // Clocking and datapath choices
    output logic [rbpa_pkg::PHASE_W-1:0] phase_select,
    output logic [rbpa_pkg::DELAY_W-1:0] delay_tap,
    output logic pcs_clock_from_user,
    output logic fixed_latency_path,
    output logic clock_correction_avail,
    output logic channel_bonding_avail
);

    // ====
    // Helpers
    function automatic logic others_low(input logic ph_cmd, input logic ph_en, input logic dly_en,
                                        input logic ph_ov, input logic dly_ov, input logic dly_byp);
        others_low = !ph_cmd && !ph_en && !dly_en && !ph_ov && !dly_ov && !dly_byp;
    endfunction : others_low

    function automatic logic step_blocked(input logic lead, input logic at_lo, input logic at_hi);
        step_blocked = lead ? at_lo : at_hi;
    endfunction : step_blocked

    // ====
    // Tap counters
    rbpa_tap_if #(.W(rbpa_pkg::PHASE_W)) ph_if ();
    rbpa_tap_if #(.W(rbpa_pkg::DELAY_W)) dl_if ();

    rbpa_tap_unit #(.W(rbpa_pkg::PHASE_W)) u_phase (
        .clock(clock),
        .reset(reset),
        .tap(ph_if.unit)
    );

    rbpa_tap_unit #(.W(rbpa_pkg::DELAY_W)) u_delay (
        .clock(clock),
        .reset(reset),
        .tap(dl_if.unit)
    );

    // ====
    // Mode decode
    rbpa_pkg::rbpa_state_t state_q;
    rbpa_pkg::rbpa_state_t state_d;
    logic hard_q;
    logic soft_q;
    logic dly_en_q;
    logic bad_slide;
    logic bypass_ok;
    logic active;
    logic auto_mode;
    logic is_master;
    logic quiet;
    logic start_hard;
    logic start_soft;
    logic start;
    logic ph_stepping;
    logic dl_stepping;
    logic ph_blocked;
    logic full_range;
    logic [rbpa_pkg::SRD_CNT_W-1:0] srd_cnt_q;
    logic srd_held;

    assign bad_slide = (slide_mode_setting == rbpa_pkg::SLIDE_AUTO)
                    || (slide_mode_setting == rbpa_pkg::SLIDE_PMA); // [RL5]
    assign bypass_ok = !elastic_buffer_use && pcs_clock_source_select && !bad_slide; // [RL3] [RL4]
    assign active = bypass_ok && !align_power_down; // [RL9]
    assign auto_mode = !manual_override_setting; // [RL21] [RL22]
    assign is_master = lane_role_select; // [RL15]
    assign quiet = others_low(phase_align_cmd, phase_align_enable, delay_align_enable,
                              phase_counter_override_en, delay_counter_override_en, delay_circuit_bypass); // [RL13]
    assign start_hard = align_hard_reset && !hard_q && quiet; // [RL6]
    assign start_soft = delay_soft_reset && !soft_q && quiet; // [RL7]
    assign start = active && auto_mode && (start_hard || start_soft);
    assign full_range = phase_delay_config_word[rbpa_pkg::TAP_RANGE_BIT]; // [RL8]
    assign srd_held = (srd_cnt_q >= rbpa_pkg::SRD_MIN_CNT);

    always_ff @(posedge clock) begin
        if (reset) begin
            hard_q <= 1'b0;
            soft_q <= 1'b0;
            dly_en_q <= 1'b0;
        end else begin
            hard_q <= align_hard_reset;
            soft_q <= delay_soft_reset;
            dly_en_q <= delay_align_enable;
        end
    end

    // ====
    // Automatic sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            rbpa_pkg::ST_IDLE: begin
                state_d = rbpa_pkg::ST_IDLE;
            end
            rbpa_pkg::ST_CENTER: begin
                if (dl_if.at_center) begin
                    state_d = (is_master || !multi_lane_setting) ? rbpa_pkg::ST_PHASE : rbpa_pkg::ST_SYNC_WAIT;
                end
            end
            rbpa_pkg::ST_SYNC_WAIT: begin
                if (group_sync_in) begin
                    state_d = rbpa_pkg::ST_PHASE; // [RL17]
                end
            end
            rbpa_pkg::ST_PHASE: begin
                if (phase_detect_aligned) begin
                    if (!is_master) begin
                        state_d = rbpa_pkg::ST_TRACK;
                    end else if (skip_delay_setting || delay_circuit_bypass) begin
                        state_d = rbpa_pkg::ST_WAIT_ALL; // [RL20] [RL12]
                    end else begin
                        state_d = rbpa_pkg::ST_DELAY;
                    end
                end
            end
            rbpa_pkg::ST_DELAY: begin
                if (delay_detect_aligned && !phase_align_done_flag) begin
                    state_d = rbpa_pkg::ST_WAIT_ALL;
                end
            end
            rbpa_pkg::ST_WAIT_ALL: begin
                if (all_lanes_done_in) begin
                    state_d = rbpa_pkg::ST_TRACK; // [RL16]
                end
            end
            rbpa_pkg::ST_TRACK: begin
                state_d = rbpa_pkg::ST_TRACK;
            end
            default: begin
                state_d = rbpa_pkg::ST_IDLE;
            end
        endcase
        if (start) begin
            state_d = rbpa_pkg::ST_CENTER;
        end
        if (!active || !auto_mode) begin
            state_d = rbpa_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= rbpa_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ====
    // Phase tap control
    assign ph_stepping = active && phase_detect_valid && !phase_detect_aligned
                      && (auto_mode ? (state_q == rbpa_pkg::ST_PHASE) : (phase_align_cmd && phase_align_enable));
    assign ph_blocked = step_blocked(phase_detect_lead, ph_if.at_lo, ph_if.at_hi);

    assign ph_if.load_center = active && (start || (!auto_mode && align_hard_reset));
    assign ph_if.seek_center = 1'b0;
    assign ph_if.step_up = ph_stepping && !phase_detect_lead; // [RL2]
    assign ph_if.step_down = ph_stepping && phase_detect_lead; // [RL2]
    assign ph_if.ovrd_en = active && phase_counter_override_en; // [RL10]
    assign ph_if.ovrd_val = phase_config_word[rbpa_pkg::PH_OVRD_HI:rbpa_pkg::PH_OVRD_LO]; // [RL10]
    assign ph_if.center = rbpa_pkg::PHASE_CENTER;
    assign ph_if.lo_lim = rbpa_pkg::PHASE_MIN;
    assign ph_if.hi_lim = rbpa_pkg::PHASE_MAX;

    // ====
    // Delay tap control
    assign dl_if.load_center = active && align_hard_reset; // [RL6]
    assign dl_if.seek_center = active && ((auto_mode && state_q == rbpa_pkg::ST_CENTER)
                            || (!auto_mode && delay_soft_reset)); // [RL7]
    assign dl_stepping = active && delay_detect_valid && !delay_circuit_bypass && is_master
                      && (auto_mode ? ((state_q == rbpa_pkg::ST_DELAY || state_q == rbpa_pkg::ST_WAIT_ALL
                                        || state_q == rbpa_pkg::ST_TRACK) && !skip_delay_setting)
                                    : delay_align_enable); // [RL12] [RL20]
    assign dl_if.step_up = dl_stepping && !delay_detect_lead && !delay_detect_aligned;
    assign dl_if.step_down = dl_stepping && delay_detect_lead && !delay_detect_aligned;
    assign dl_if.ovrd_en = active && delay_counter_override_en; // [RL11]
    assign dl_if.ovrd_val = delay_config_word[rbpa_pkg::DLY_OVRD_HI:rbpa_pkg::DLY_OVRD_LO]; // [RL11]
    assign dl_if.center = rbpa_pkg::DELAY_CENTER;
    assign dl_if.lo_lim = full_range ? rbpa_pkg::DELAY_FULL_MIN : rbpa_pkg::DELAY_HALF_MIN; // [RL8]
    assign dl_if.hi_lim = full_range ? rbpa_pkg::DELAY_FULL_MAX : rbpa_pkg::DELAY_HALF_MAX; // [RL8]

    // ====
    // Soft-reset-done flag with minimum hold
    logic srd_set;
    logic srd_clr;

    assign srd_set = active && dl_if.at_center
                  && (auto_mode ? (state_q == rbpa_pkg::ST_CENTER) : delay_soft_reset);
    assign srd_clr = !active || (auto_mode ? start : !delay_soft_reset);

    always_ff @(posedge clock) begin
        if (reset) begin
            soft_reset_done_flag <= 1'b0;
        end else if (srd_set) begin
            soft_reset_done_flag <= 1'b1;
        end else if (srd_clr && srd_held) begin
            soft_reset_done_flag <= 1'b0; // [RL24]
        end
    end

    always_ff @(posedge clock) begin
        if (reset || !soft_reset_done_flag) begin
            srd_cnt_q <= '0;
        end else if (!srd_held) begin
            srd_cnt_q <= srd_cnt_q + rbpa_pkg::SRD_CNT_W'(1); // [RL24]
        end
    end

    // ====
    // Phase-align-done flag
    logic done_set;
    logic done_clr;

    assign done_set = active && (auto_mode
        ? ((state_q == rbpa_pkg::ST_PHASE && phase_detect_aligned)
           || (state_q == rbpa_pkg::ST_DELAY && delay_detect_aligned && !phase_align_done_flag))
        : ((phase_align_cmd && phase_detect_aligned) || (delay_align_enable && delay_detect_aligned)));
    assign done_clr = !active || start || (auto_mode && state_q == rbpa_pkg::ST_CENTER)
                   || (auto_mode && state_q == rbpa_pkg::ST_DELAY && state_d == rbpa_pkg::ST_DELAY
                       && !delay_detect_aligned)
                   || (!auto_mode && delay_align_enable && !dly_en_q); // [RL14]

    always_ff @(posedge clock) begin
        if (reset) begin
            phase_align_done_flag <= 1'b0;
        end else if (done_clr && !done_set) begin
            phase_align_done_flag <= 1'b0;
        end else if (done_set) begin
            phase_align_done_flag <= 1'b1; // [RL14]
        end
    end

    // ====
    // Error flag: a step asked for past the end of the phase range
    always_ff @(posedge clock) begin
        if (reset) begin
            phase_align_error_flag <= 1'b0;
        end else if (ph_stepping && ph_blocked) begin
            phase_align_error_flag <= 1'b1;
        end else if (start || (!auto_mode && phase_align_cmd && !phase_align_done_flag && !ph_blocked)) begin
            phase_align_error_flag <= 1'b0;
        end
    end

    // ====
    // Group sync and completion
    always_ff @(posedge clock) begin
        if (reset) begin
            group_sync_out <= 1'b0;
            sync_done_flag <= 1'b0;
        end else begin
            group_sync_out <= auto_mode && active && is_master && multi_lane_setting
                           && (state_d == rbpa_pkg::ST_PHASE || state_d == rbpa_pkg::ST_DELAY
                               || state_d == rbpa_pkg::ST_WAIT_ALL); // [RL17] [RL19]
            sync_done_flag <= auto_mode && active && is_master && (state_d == rbpa_pkg::ST_TRACK); // [RL18]
        end
    end

    // ====
    // Datapath and clock choice outputs
    always_ff @(posedge clock) begin
        if (reset) begin
            pcs_clock_from_user <= 1'b0;
            fixed_latency_path <= 1'b0;
            clock_correction_avail <= 1'b1;
            channel_bonding_avail <= 1'b1;
            config_fault <= 1'b0;
        end else begin
            pcs_clock_from_user <= pcs_clock_source_select; // [RL3]
            fixed_latency_path <= !elastic_buffer_use; // [RL1] [RL4]
            clock_correction_avail <= elastic_buffer_use; // [RL1]
            channel_bonding_avail <= elastic_buffer_use; // [RL1]
            config_fault <= !elastic_buffer_use && (bad_slide || !pcs_clock_source_select); // [RL5]
        end
    end

    assign phase_select = ph_if.value;
    assign delay_tap = dl_if.value;

endmodule : rbpa_align

// ---- tb/rbpa_align_checker.sv ----
// Purpose: Port assertions for the alignment controller.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to the top module.
`timescale 1ns/1ps
module rbpa_align_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Controls
    input wire logic elastic_buffer_use,
    input wire logic align_hard_reset,
    input wire logic align_power_down,
    input wire logic phase_counter_override_en,
    input wire logic delay_counter_override_en,
    input wire logic all_lanes_done_in,
    input wire logic [23:0] phase_config_word,
    input wire logic [15:0] delay_config_word,
    // Status
    input wire logic phase_align_done_flag,
    input wire logic soft_reset_done_flag,
    input wire logic sync_done_flag,
    input wire logic [4:0] phase_select,
    input wire logic [8:0] delay_tap,
    input wire logic fixed_latency_path,
    input wire logic clock_correction_avail,
    input wire logic channel_bonding_avail
);
    // ====
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    logic [4:0] srd_cnt_q;
    always_ff @(posedge clock) begin
        if (reset || !soft_reset_done_flag) begin
            srd_cnt_q <= 5'h00;
        end else if (srd_cnt_q != 5'h1f) begin
            srd_cnt_q <= srd_cnt_q + 5'h01;
        end
    end
    sequence srd_rise_s;
        $rose(soft_reset_done_flag);
    endsequence
    sequence jump_s;
        align_hard_reset && !delay_counter_override_en && !align_power_down && !elastic_buffer_use;
    endsequence
    byp_path_a: assert property (
        !elastic_buffer_use |=> fixed_latency_path && !(clock_correction_avail || channel_bonding_avail))
        else $error("bypass path flags wrong");
    buf_use_a: assert property (elastic_buffer_use |=> !fixed_latency_path && clock_correction_avail)
        else $error("buffered path flags wrong");
    hard_center_a: assert property (jump_s |=> delay_tap == rbpa_pkg::DELAY_CENTER)
        else $error("hard reset missed centre");
    tap_walk_a: assert property (
        !$past(align_hard_reset) && !$past(delay_counter_override_en)
        |-> (delay_tap - $past(delay_tap)) inside {9'h000, 9'h001, 9'h1ff}) else $error("delay tap jumped");
    srd_center_a: assert property (srd_rise_s |-> delay_tap == rbpa_pkg::DELAY_CENTER)
        else $error("soft reset done off centre");
    srd_hold_a: assert property (
        $fell(soft_reset_done_flag) && !align_power_down && !$past(align_power_down)
        |-> srd_cnt_q >= rbpa_pkg::SRD_MIN_CYC) else $error("soft reset done too short");
    ph_ovrd_a: assert property (
        phase_counter_override_en && !align_power_down |=> phase_select == $past(phase_config_word[10:6]))
        else $error("phase override value wrong");
    dl_ovrd_a: assert property (
        delay_counter_override_en && !align_power_down |=> delay_tap == $past(delay_config_word[14:6]))
        else $error("delay override value wrong");
    pd_clear_a: assert property (align_power_down |=> !(phase_align_done_flag || sync_done_flag))
        else $error("flags kept in power down");
    sync_cause_a: assert property ($rose(sync_done_flag) |-> $past(all_lanes_done_in))
        else $error("sync done without all lanes");
endmodule : rbpa_align_checker

bind rbpa_align rbpa_align_checker i_rbpa_align_checker (.*);

// ---- tb/rbpa_lane_ctrl.sv ----
// Purpose: Interconnect model for single-lane automatic mode.
// Assumes: Start only once the receiver is locked.
// Notes: Only the soft-reset-done flag is synchronised before use.
`timescale 1ns/1ps
module rbpa_lane_ctrl (
    // Clock and request
    input wire logic clock,
    input wire logic start,
    // Lane flags
    input wire logic phase_align_done_flag,
    input wire logic soft_reset_done_flag,
    // Alignment controls
    output logic delay_soft_reset,
    output logic phase_align_cmd,
    output logic phase_align_enable,
    output logic lane_role_select,
    output logic all_lanes_done_in
);
    // ====
    // Control
    logic [1:0] srd_sync_q;
    assign phase_align_cmd = 1'h0;
    assign phase_align_enable = 1'h0;
    assign lane_role_select = 1'h1;
    assign all_lanes_done_in = phase_align_done_flag;
    initial delay_soft_reset = 1'h0;
    always @(posedge clock) begin
        srd_sync_q <= {srd_sync_q[0], soft_reset_done_flag};
        if (start) begin
            delay_soft_reset <= 1'h1;
        end else if (srd_sync_q[1] === 1'h1) begin
            delay_soft_reset <= 1'h0;
        end
    end
endmodule : rbpa_lane_ctrl

// ---- tb/test_rbpa_align.sv ----
// Purpose: Self-checking bench for the alignment controller.
// Assumes: Single lane, automatic mode, master role.
// Notes: Detector inputs stand in for the sensors.
`timescale 1ns/1ps
module test_rbpa_align;
    // ====
    // Stimulus and checks
    logic clock = '0, reset = '1, start = '0, align_hard_reset = '0, align_power_down = '0;
    logic phase_counter_override_en = '0, delay_counter_override_en = '0, delay_circuit_bypass = '0;
    logic delay_align_enable = '0, elastic_buffer_use = '1, pcs_clock_source_select = '0, group_sync_in;
    logic multi_lane_setting = '0, skip_delay_setting = '0, manual_override_setting = '0;
    logic [23:0] phase_config_word = '0;
    logic [15:0] phase_delay_config_word = '0, delay_config_word = '0;
    logic [1:0] slide_mode_setting = '0;
    logic phase_detect_valid = '0, phase_detect_lead = '0, phase_detect_aligned = '0;
    logic delay_detect_valid = '0, delay_detect_lead = '0, delay_detect_aligned = '0;
    logic delay_soft_reset, phase_align_cmd, phase_align_enable, lane_role_select, all_lanes_done_in;
    logic group_sync_out, phase_align_done_flag, soft_reset_done_flag, sync_done_flag, phase_align_error_flag;
    logic config_fault, pcs_clock_from_user, fixed_latency_path, clock_correction_avail, channel_bonding_avail;
    logic [4:0] phase_select;
    logic [8:0] delay_tap;
    logic [15:0] notes[$];
    logic srd_q = '0, sync_q = '0, done_q = '0;
    int failures = 0, n_checks = 0, rises = 0, n_srd = 0, n_sync = 0, seed = 5675, n, r0;
    always #2.5 clock = ~clock;
    rbpa_align i_rbpa_align (.*);
    rbpa_lane_ctrl i_rbpa_lane_ctrl (.*);
    assign group_sync_in = group_sync_out;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    task automatic wt(ref int c, input int t);
        for (int i = 0; i < 400; i++) begin
            @(negedge clock);
            if (c >= t) return;
        end
        failures++;
        wrap_up();
    endtask : wt
    always @(negedge clock) begin
        srd_q <= soft_reset_done_flag;
        sync_q <= sync_done_flag;
        done_q <= phase_align_done_flag;
        if (phase_align_done_flag === 1'h1 && !done_q) rises++;
        if (soft_reset_done_flag === 1'h1 && !srd_q) n_srd++;
        if (sync_done_flag === 1'h1 && !sync_q) n_sync++;
        if ((soft_reset_done_flag && !srd_q) || (sync_done_flag && !sync_q))
            chk({sync_done_flag, delay_tap}, notes.size() > 0 ? notes.pop_front() : 16'hx);
    end
    initial begin
        repeat (16) @(negedge clock);
        reset = 1'h0;
        repeat (2) @(negedge clock);
        chk({fixed_latency_path, clock_correction_avail, channel_bonding_avail}, 16'h3);
        elastic_buffer_use = 1'h0;
        pcs_clock_source_select = 1'h1;
        phase_delay_config_word = 16'($random(seed));
        for (int s = 0; s < 4; s++) begin
            slide_mode_setting = 2'(s);
            repeat (2) @(negedge clock);
            chk(16'(config_fault), 16'(s & 1));
        end
        chk({fixed_latency_path, clock_correction_avail, channel_bonding_avail, pcs_clock_from_user}, 16'h9);
        slide_mode_setting = 2'h0;
        @(negedge clock);
        notes.push_back(16'h100);
        align_hard_reset = 1'h1;
        @(negedge clock);
        chk(16'(delay_tap), 16'h100);
        align_hard_reset = 1'h0;
        wt(n_srd, 1);
        for (int k = 0; k < 4; k++) begin
            repeat (24) @(negedge clock);
            skip_delay_setting = k[0];
            n = 1 + ($random(seed) & 7);
            notes.push_back(16'h100);
            notes.push_back({7'h01, k[0] ? 9'h100 : 9'(256 - n)});
            r0 = rises;
            start = 1'h1;
            @(negedge clock);
            start = 1'h0;
            wt(n_srd, k + 2);
            phase_detect_valid = 1'h1;
            repeat (2) @(negedge clock);
            phase_detect_aligned = 1'h1;
            wt(rises, r0 + 1);
            {phase_detect_valid, phase_detect_aligned} = 2'h0;
            {delay_detect_valid, delay_detect_lead} = 2'h3;
            repeat (n) @(negedge clock);
            delay_detect_aligned = 1'h1;
            wt(n_sync, k + 1);
            chk(16'(rises - r0), k[0] ? 16'h1 : 16'h2);
            chk(16'(phase_align_error_flag), 16'h0);
            {delay_detect_valid, delay_detect_lead, delay_detect_aligned} = 3'h0;
        end
        phase_config_word = 24'($random(seed));
        delay_config_word = 16'($random(seed));
        {phase_counter_override_en, delay_counter_override_en} = 2'h3;
        repeat (2) @(negedge clock);
        chk({2'h0, phase_select, delay_tap}, {2'h0, phase_config_word[10:6], delay_config_word[14:6]});
        align_power_down = 1'h1;
        repeat (2) @(negedge clock);
        chk({phase_align_done_flag, sync_done_flag}, 16'h0);
        chk(16'(notes.size()), 16'h0);
        chk(16'(group_sync_out), 16'h0);
        wrap_up();
    end
endmodule : test_rbpa_align
